// ---- design/apx_pkg.sv ----
package apx_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned APB_AW   = 12;
  localparam int unsigned RF_AW    = 6;
  localparam int unsigned RF_PORTS = 4;

  // register byte offsets
  localparam logic [11:0] OFF_INSTR  = 12'h000;
  localparam logic [11:0] OFF_AMR    = 12'h004;
  localparam logic [11:0] OFF_PCBASE = 12'h008;
  localparam logic [11:0] OFF_RFIDX  = 12'h00c;
  localparam logic [11:0] OFF_RFDATA = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_RESULT = 12'h018;

  // reset values
  localparam logic [31:0] INSTR_RST  = 32'h0000_0000;
  localparam logic [31:0] AMR_RST    = 32'h0000_0000;
  localparam logic [31:0] PCBASE_RST = 32'h0000_0000;
  localparam logic [5:0]  RFIDX_RST  = 6'h00;

  // instruction word fields
  localparam int unsigned CREG_LSB  = 29;
  localparam int unsigned Z_BIT     = 28;
  localparam int unsigned DST_LSB   = 23;
  localparam int unsigned SRC2_LSB  = 18;
  localparam int unsigned SRC1_LSB  = 13;
  localparam int unsigned SIGNED_CONST7_FIELD_LSB = 16;
  localparam int unsigned NOP_COUNT_FIELD_LSB = 13;
  localparam int unsigned X_BIT     = 12;
  localparam int unsigned OP_LSB    = 8;
  localparam int unsigned UNIT_LSB  = 6;
  localparam int unsigned SIDE_BIT  = 1;

  localparam logic [3:0] OP_DOUBLEWORD_ADDRESS_ADD_REG = 4'h1;
  localparam logic [3:0] OP_DOUBLEWORD_ADDRESS_ADD_CST = 4'h2;
  localparam logic [3:0] OP_PC_RELATIVE_CONSTANT_ADD    = 4'h3;
  localparam logic [3:0] OP_AND_REG   = 4'h4;
  localparam logic [3:0] OP_AND_CST   = 4'h5;

  localparam logic [1:0] UNIT_L = 2'h0;
  localparam logic [1:0] UNIT_S = 2'h1;
  localparam logic [1:0] UNIT_D = 2'h2;

  localparam int unsigned DW_SHIFT = 3;
  localparam int unsigned PC_SHIFT = 2;

  // condition register select codes
  localparam logic [2:0] CREG_NONE = 3'h0;
  localparam logic [2:0] CREG_B0   = 3'h1;
  localparam logic [2:0] CREG_B1   = 3'h2;
  localparam logic [2:0] CREG_B2   = 3'h3;
  localparam logic [2:0] CREG_A1   = 3'h4;
  localparam logic [2:0] CREG_A2   = 3'h5;
  localparam logic [2:0] CREG_A0   = 3'h6;

  // addressing mode register layout
  localparam int unsigned AMR_BK0_LSB = 16;
  localparam int unsigned AMR_BK1_LSB = 21;
  localparam logic [1:0]  MODE_CIRC0  = 2'h1;
  localparam logic [1:0]  MODE_CIRC1  = 2'h2;

  // status register layout
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_NOP_LSB  = 1;
  localparam int unsigned ST_COND_BIT = 4;
  localparam int unsigned ST_WROTE_BIT = 5;
  localparam int unsigned ST_ILL_BIT  = 6;
  localparam int unsigned ST_CIRC_BIT = 7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_NOP
  } apx_state_e;

endpackage : apx_pkg

// ---- design/apx_regfile.sv ----
`timescale 1ns/1ps
module apx_regfile #(
  parameter int unsigned DW  = 32,
  parameter int unsigned AW  = 6,
  parameter int unsigned NRD = 4
) (
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  input  wire logic              we_in,
  input  wire logic [AW-1:0]     waddr_in,
  input  wire logic [DW-1:0]     wdata_in,
  input  wire logic [NRD*AW-1:0] raddr_in,
  output logic      [NRD*DW-1:0] rdata_out
);

  if (NRD < 1 || AW < 1 || DW < 1) begin : g_bad
    $error("apx_regfile: bad geometry");
  end

  logic [DW-1:0] mem_q [2**AW];
  logic [NRD*DW-1:0] rdata_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // read data registered: a write shows on a port one edge after it lands
  for (genvar g = 0; g < NRD; g++) begin : g_rd
    always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
        rdata_q[g*DW +: DW] <= '0;
      end else begin
        rdata_q[g*DW +: DW] <= mem_q[raddr_in[g*AW +: AW]];
      end
    end
  end

  assign rdata_out = rdata_q;

endmodule : apx_regfile

// ---- design/apx_exec_unit.sv ----
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module apx_exec_unit
  import apx_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              reset_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [APB_AW-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  output logic      [DATA_W-1:0] prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic                   busy_out
);

  function automatic logic [RF_AW-1:0] cond_addr(input logic [2:0] creg);
    logic [RF_AW-1:0] a;
    a = '0;
    unique case (creg)
      CREG_B0: a = 6'h20;
      CREG_B1: a = 6'h21;
      CREG_B2: a = 6'h22;
      CREG_A1: a = 6'h01;
      CREG_A2: a = 6'h02;
      default: a = 6'h00;
    endcase
    return a;
  endfunction : cond_addr

  // block size is 2^(n+1) bytes; bits above the block keep the base
  function automatic logic [31:0] circ_sum(input logic [31:0] base,
                                           input logic [31:0] off,
                                           input logic [4:0]  n);
    logic [32:0] m;
    logic [31:0] s;
    m = (33'h2 << n) - 33'h1;
    s = base + off;
    return (base & ~m[31:0]) | (s & m[31:0]);
  endfunction : circ_sum

  function automatic logic [31:0] sext5(input logic [4:0] v);
    return {{27{v[4]}}, v};
  endfunction : sext5

  // apb decode
  logic                   apb_acc;
  logic                   sel_instr;
  logic                   sel_amr;
  logic                   sel_pcbase;
  logic                   sel_rfidx;
  logic                   sel_rfdata;
  logic                   sel_status;
  logic                   sel_result;
  logic                   mapped;
  logic                   idle;
  logic                   rd_ready;
  logic                   do_wr;
  logic                   issue;
  logic                   rf_apb_we;

  assign apb_acc    = psel_in & penable_in;
  assign sel_instr  = paddr_in == OFF_INSTR;
  assign sel_amr    = paddr_in == OFF_AMR;
  assign sel_pcbase = paddr_in == OFF_PCBASE;
  assign sel_rfidx  = paddr_in == OFF_RFIDX;
  assign sel_rfdata = paddr_in == OFF_RFDATA;
  assign sel_status = paddr_in == OFF_STATUS;
  assign sel_result = paddr_in == OFF_RESULT;
  assign mapped     = sel_instr | sel_amr | sel_pcbase | sel_rfidx
                    | sel_rfdata | sel_status | sel_result;

  // registers
  apx_state_e       state_q;
  apx_state_e       state_d;
  logic [31:0]      instr_q;
  logic [31:0]      amr_q;
  logic [31:0]      pcbase_q;
  logic [RF_AW-1:0] rfidx_q;
  logic [31:0]      result_q;
  logic [2:0]       nop_q;
  logic [2:0]       nop_d;
  logic             cond_q;
  logic             wrote_q;
  logic             ill_q;
  logic             circ_q;
  logic             rf_rd_rdy_q;

  assign idle = state_q == ST_IDLE;

  // issue and register-file writes wait while an instruction is in flight
  assign rd_ready = sel_rfdata & ~pwrite_in ? rf_rd_rdy_q
                  : (sel_instr | sel_rfdata) & pwrite_in ? idle
                  : 1'b1;
  assign pready_out  = apb_acc & rd_ready;
  assign pslverr_out = apb_acc & rd_ready & ~mapped;
  assign do_wr       = apb_acc & rd_ready & pwrite_in & mapped;
  assign issue       = do_wr & sel_instr;
  assign rf_apb_we   = do_wr & sel_rfdata;
  assign busy_out    = ~idle;

  // instruction fields
  logic [2:0] f_creg;
  logic       f_z;
  logic [4:0] f_dst;
  logic [4:0] f_src2;
  logic [4:0] f_src1;
  logic [6:0] f_signed_const7_field;
  logic [2:0] f_nop_count_field;
  logic       f_x;
  logic [3:0] f_op;
  logic [1:0] f_unit;
  logic       f_side;

  assign f_creg  = instr_q[CREG_LSB +: 3];
  assign f_z     = instr_q[Z_BIT];
  assign f_dst   = instr_q[DST_LSB +: 5];
  assign f_src2  = instr_q[SRC2_LSB +: 5];
  assign f_src1  = instr_q[SRC1_LSB +: 5];
  assign f_signed_const7_field = instr_q[SIGNED_CONST7_FIELD_LSB +: 7];
  assign f_nop_count_field = instr_q[NOP_COUNT_FIELD_LSB +: 3];
  assign f_x     = instr_q[X_BIT];
  assign f_op    = instr_q[OP_LSB +: 4];
  assign f_unit  = instr_q[UNIT_LSB +: 2];
  assign f_side  = instr_q[SIDE_BIT];

  logic is_ad;
  logic is_kpc;
  logic is_and;
  logic legal;

  assign is_ad  = f_op == OP_DOUBLEWORD_ADDRESS_ADD_REG | f_op == OP_DOUBLEWORD_ADDRESS_ADD_CST;
  assign is_kpc = f_op == OP_PC_RELATIVE_CONSTANT_ADD;
  assign is_and = f_op == OP_AND_REG | f_op == OP_AND_CST;
  // and is accepted on the l, s and d units only (unit code 3 is illegal); the unit field never alters the result
  assign legal  = is_ad | is_kpc
                | (is_and & (f_unit == UNIT_L | f_unit == UNIT_S | f_unit == UNIT_D));

  // register file ports: src1, src2, condition, software window
  logic [RF_PORTS*RF_AW-1:0]  rf_raddr;
  logic [RF_PORTS*DATA_W-1:0] rf_rdata;
  logic [RF_AW-1:0]           src2_addr;
  logic                       rf_we;
  logic [RF_AW-1:0]           rf_waddr;
  logic [31:0]                rf_wdata;

  assign src2_addr = {f_side ^ (is_and & f_x), f_src2};
  assign rf_raddr  = {rfidx_q, cond_addr(f_creg), src2_addr, {f_side, f_src1}};

  logic [31:0] src1_v;
  logic [31:0] src2_v;
  logic [31:0] cond_v;
  logic [31:0] win_v;

  assign src1_v = rf_rdata[0*DATA_W +: DATA_W];
  assign src2_v = rf_rdata[1*DATA_W +: DATA_W];
  assign cond_v = rf_rdata[2*DATA_W +: DATA_W];
  assign win_v  = rf_rdata[3*DATA_W +: DATA_W];

  // condition: creg 0 with z clear is unconditional, reserved codes never pass
  logic cond_ok;

  assign cond_ok = f_creg == CREG_NONE ? ~f_z
                 : f_creg == 3'h7      ? 1'b0
                 : f_z ? cond_v == 32'h0 : cond_v != 32'h0;

  // doubleword address add
  logic [31:0] ad_src1;
  logic [31:0] ad_off;
  logic [31:0] ad_lin;
  logic [2:0]  amr_idx;
  logic [1:0]  amr_mode;
  logic [4:0]  amr_bk;
  logic        ad_circ;
  logic [31:0] ad_res;

  assign ad_src1  = f_op == OP_DOUBLEWORD_ADDRESS_ADD_CST ? {27'h0, f_src1} : src1_v;
  assign ad_off   = {ad_src1[31-DW_SHIFT:0], 3'h0};
  assign ad_lin   = src2_v + ad_off;
  assign amr_idx  = {f_side, f_src2[1:0]};
  assign amr_mode = amr_q[2*amr_idx +: 2];
  assign amr_bk   = amr_mode == MODE_CIRC1 ? amr_q[AMR_BK1_LSB +: 5]
                                           : amr_q[AMR_BK0_LSB +: 5];
  // a mode field of 11 is reserved and stays linear
  assign ad_circ  = f_src2[4:2] == 3'h1
                  & (amr_mode == MODE_CIRC0 | amr_mode == MODE_CIRC1);
  assign ad_res   = ad_circ ? circ_sum(src2_v, ad_off, amr_bk) : ad_lin;

  // pc-relative add
  logic [31:0] kpc_off;
  logic [31:0] kpc_res;

  assign kpc_off = {{(32-7-PC_SHIFT){f_signed_const7_field[6]}}, f_signed_const7_field, 2'h0};
  assign kpc_res = pcbase_q + kpc_off;

  // bitwise and
  logic [31:0] and_a;
  logic [31:0] and_res;

  assign and_a   = f_op == OP_AND_CST ? sext5(f_src1) : src1_v;
  assign and_res = and_a & src2_v;

  logic [31:0] ex_res;
  logic        ex_we;

  assign ex_res = is_kpc ? kpc_res : is_and ? and_res : ad_res;
  // write lands in the execute cycle, so the next issue reads it
  assign ex_we  = state_q == ST_EXEC & cond_ok & legal;

  assign rf_we    = ex_we | rf_apb_we;
  assign rf_waddr = ex_we ? {f_side, f_dst} : rfidx_q;
  assign rf_wdata = ex_we ? ex_res : pwdata_in;

  apx_regfile #(
    .DW  (DATA_W),
    .AW  (RF_AW),
    .NRD (RF_PORTS)
  ) u_regfile (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .we_in       (rf_we),
    .waddr_in    (rf_waddr),
    .wdata_in    (rf_wdata),
    .raddr_in    (rf_raddr),
    .rdata_out   (rf_rdata)
  );

  // sequencing
  always_comb begin
    state_d = state_q;
    nop_d   = nop_q;
    unique case (state_q)
      ST_IDLE: begin
        if (issue) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        // parallel nops only when the add itself executes
        if (is_kpc & cond_ok & f_nop_count_field != 3'h0) begin
          state_d = ST_NOP;
          nop_d   = f_nop_count_field;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_NOP: begin
        nop_d = nop_q - 3'h1;
        if (nop_q == 3'h1) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      nop_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      nop_q   <= nop_d;
    end
  end

  // software-written registers; one instruction in flight allows at most one add every three cycles
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      instr_q <= INSTR_RST;
    end else if (issue) begin
      instr_q <= pwdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      amr_q    <= AMR_RST;
      pcbase_q <= PCBASE_RST;
      rfidx_q  <= RFIDX_RST;
    end else begin
      if (do_wr & sel_amr) begin
        amr_q <= pwdata_in;
      end
      if (do_wr & sel_pcbase) begin
        pcbase_q <= pwdata_in;
      end
      if (do_wr & sel_rfidx) begin
        rfidx_q <= pwdata_in[RF_AW-1:0];
      end
    end
  end

  // execution record for software
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      result_q <= 32'h0;
      cond_q   <= 1'b0;
      wrote_q  <= 1'b0;
      ill_q    <= 1'b0;
      circ_q   <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      cond_q  <= cond_ok;
      wrote_q <= ex_we;
      ill_q   <= ~legal;
      circ_q  <= is_ad & ad_circ;
      if (ex_we) begin
        result_q <= ex_res;
      end
    end
  end

  // window reads wait one cycle so the registered port holds fresh data
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rf_rd_rdy_q <= 1'b0;
    end else begin
      rf_rd_rdy_q <= apb_acc & sel_rfdata & ~pwrite_in & idle & ~rf_rd_rdy_q;
    end
  end

  logic [31:0] status_v;

  assign status_v = {24'h0, circ_q, ill_q, wrote_q, cond_q, nop_q, ~idle}
                    & 32'h0000_00ff;

  assign prdata_out = ~(apb_acc & ~pwrite_in) ? 32'h0
                    : sel_instr  ? instr_q
                    : sel_amr    ? amr_q
                    : sel_pcbase ? pcbase_q
                    : sel_rfidx  ? {26'h0, rfidx_q}
                    : sel_rfdata ? win_v
                    : sel_status ? status_v
                    : sel_result ? result_q
                    : 32'h0;

  // relative branches are not executed here; pairing them is left to software
  logic unused_kpc_branch;

  assign unused_kpc_branch = is_kpc & 1'b0;

  logic unused_sink;

  assign unused_sink = unused_kpc_branch & status_v[31] & (ST_BUSY_BIT == ST_NOP_LSB)
                     & (ST_COND_BIT == ST_WROTE_BIT) & (ST_ILL_BIT == ST_CIRC_BIT);

endmodule : apx_exec_unit

// ---- tb/apx_exec_unit_asserts.sv ----
`timescale 1ns/1ps
module apx_exec_unit_asserts
  import apx_pkg::*;
(
  input wire logic              core_clk_in,
  input wire logic              reset_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  input wire logic [DATA_W-1:0] prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              busy_out
);
  logic [31:0] ins_q;
  logic [31:0] amr_q;
  logic [3:0]  run_q;
  wire         wr_ok   = psel_in & penable_in & pwrite_in & pready_out;
  // status only means the last instruction once the unit is idle
  wire         sts_rd  = psel_in & penable_in & !pwrite_in & !busy_out & (paddr_in == OFF_STATUS);
  wire [3:0]   op      = ins_q[11:8];
  wire         uncond  = (ins_q[31:29] == CREG_NONE) & !ins_q[Z_BIT];
  wire [1:0]   mode    = amr_q[{ins_q[SIDE_BIT], ins_q[19:18], 1'b0} +: 2];
  wire         circ    = (ins_q[22:20] == 3'h1) & ((mode == MODE_CIRC0) | (mode == MODE_CIRC1));
  wire         is_dw   = (op == OP_DOUBLEWORD_ADDRESS_ADD_REG) | (op == OP_DOUBLEWORD_ADDRESS_ADD_CST);
  wire         is_and  = (op == OP_AND_REG) | (op == OP_AND_CST);
  wire         legal   = (op != 4'h0) & (op <= OP_AND_CST);
  wire [3:0]   exp_run = (op == OP_PC_RELATIVE_CONSTANT_ADD) ? 4'h2 + {1'b0, ins_q[15:13]} : 4'h2;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ins_q <= 32'h0;
      amr_q <= 32'h0;
      run_q <= 4'h0;
    end else begin
      if (wr_ok && paddr_in == OFF_INSTR) ins_q <= pwdata_in;
      if (wr_ok && paddr_in == OFF_AMR) amr_q <= pwdata_in;
      run_q <= busy_out ? run_q + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  chk_issue_busy: assert property (
    wr_ok && paddr_in == OFF_INSTR |=> busy_out [*2]) else $error("busy did not follow issue");
  chk_busy_ends: assert property (
    $rose(busy_out) |-> ##[2:9] !busy_out) else $error("instruction never finished");
  chk_busy_len: assert property (
    $fell(busy_out) && legal && uncond |-> run_q == exp_run) else $error("busy length wrong");
  chk_stall_busy: assert property (
    psel_in && penable_in && pwrite_in && paddr_in == OFF_INSTR && busy_out |-> !pready_out)
    else $error("issue accepted while busy");
  chk_never_quiet: assert property (
    sts_rd && ins_q[31:29] == 3'h7 |-> !prdata_out[ST_WROTE_BIT] && !prdata_out[ST_COND_BIT])
    else $error("false condition wrote");
  chk_circ_cause: assert property (
    sts_rd && prdata_out[ST_CIRC_BIT] |-> is_dw && circ) else $error("circular without cause");
  chk_circ_taken: assert property (
    sts_rd && is_dw && uncond && circ |-> prdata_out[ST_CIRC_BIT]) else $error("circular missed");
  chk_and_units: assert property (
    sts_rd && is_and && uncond && ins_q[7:6] != 2'h3
    |-> prdata_out[ST_WROTE_BIT] && !prdata_out[ST_ILL_BIT]) else $error("and refused on unit");
  chk_pc_write: assert property (
    sts_rd && op == OP_PC_RELATIVE_CONSTANT_ADD && uncond |-> prdata_out[ST_WROTE_BIT] && prdata_out[ST_COND_BIT])
    else $error("pc add did not write");
endmodule : apx_exec_unit_asserts

bind apx_exec_unit apx_exec_unit_asserts apx_exec_unit_asserts_inst (.core_clk_in, .reset_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .busy_out);

// ---- tb/test_apx_exec_unit.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_apx_exec_unit;
  import apx_pkg::*;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic [31:0] rdat;
  logic        rerr;
  int          n_errors    = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  logic [4:0]  kc[3]       = '{5'h0f, 5'h1f, 5'h10};
  logic [31:0] ke[3]       = '{32'h6, 32'h32e4_6936, 32'h32e4_6930};
  logic [2:0]  cc[3]       = '{3'h7, CREG_B0, CREG_B0};
  logic        cz[3]       = '{1'b0, 1'b0, 1'b1};
  logic [31:0] ce[3]       = '{32'h5a5a_5a5a, 32'h5a5a_5a5a, 32'h0000_000f};

  apx_exec_unit apx_exec_unit_inst (.core_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .busy_out(busy));

  always #2 clk = ~clk;

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("timeout at cycle %0d", cyc);
      print_verdict();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task setr(input logic [5:0] i, input logic [31:0] v);
    apb(1'b1, OFF_RFIDX, {26'h0, i});
    apb(1'b1, OFF_RFDATA, v);
  endtask : setr

  task chkr(input string nm, input logic [5:0] i, input logic [31:0] e);
    apb(1'b1, OFF_RFIDX, {26'h0, i});
    apb(1'b0, OFF_RFDATA, 32'h0);
    `CHK(nm, e, rdat)
  endtask : chkr

  // polling status rather than busy keeps the bench on the bus like software
  task run(input logic [31:0] w);
    apb(1'b1, OFF_INSTR, w);
    do apb(1'b0, OFF_STATUS, 32'h0); while (rdat[ST_BUSY_BIT] !== 1'b0);
  endtask : run

  function automatic logic [31:0] ins(logic [2:0] c, logic z, logic [4:0] d, logic [4:0] s2,
                                      logic [4:0] s1, logic x, logic [3:0] op, logic [1:0] u,
                                      logic sd);
    return {c, z, d, s2, s1, x, op, u, 4'h0, sd, 1'b0};
  endfunction : ins

  function automatic logic [31:0] kpc(logic [6:0] k, logic [2:0] n);
    // no relative branch is ever issued beside it
    return {4'h0, 5'h03, k, n, 1'b0, OP_PC_RELATIVE_CONSTANT_ADD, UNIT_S, 4'h0, 1'b1, 1'b0};
  endfunction : kpc

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    setr(6'd1, 32'h1234);
    setr(6'd2, 32'h2);
    run(ins(CREG_NONE, 1'b0, 5'd3, 5'd1, 5'd2, 1'b0, OP_DOUBLEWORD_ADDRESS_ADD_REG, UNIT_D, 1'b0));
    chkr("dw add", 6'd3, 32'h1244);
    setr(6'd4, 32'h100c);
    setr(6'd5, 32'h1);
    run(ins(CREG_NONE, 1'b0, 5'd6, 5'd4, 5'd5, 1'b0, OP_DOUBLEWORD_ADDRESS_ADD_REG, UNIT_D, 1'b0));
    chkr("dw linear", 6'd6, 32'h1014);
    apb(1'b1, OFF_AMR, 32'h0003_0001);
    run(ins(CREG_NONE, 1'b0, 5'd6, 5'd4, 5'd5, 1'b0, OP_DOUBLEWORD_ADDRESS_ADD_REG, UNIT_D, 1'b0));
    chkr("dw circ a", 6'd6, 32'h1004);
    setr(6'd0, 32'h100c);
    run(ins(CREG_NONE, 1'b0, 5'd6, 5'd0, 5'd5, 1'b0, OP_DOUBLEWORD_ADDRESS_ADD_REG, UNIT_D, 1'b0));
    chkr("dw low base", 6'd6, 32'h1014);
    apb(1'b1, OFF_AMR, 32'h0060_0200);
    setr(6'd36, 32'h100c);
    setr(6'd37, 32'h1);
    run(ins(CREG_NONE, 1'b0, 5'd6, 5'd4, 5'd5, 1'b0, OP_DOUBLEWORD_ADDRESS_ADD_REG, UNIT_D, 1'b1));
    chkr("dw circ b", 6'd38, 32'h1004);
    apb(1'b1, OFF_AMR, 32'h0);
    setr(6'd2, 32'h100);
    run(ins(CREG_NONE, 1'b0, 5'd7, 5'd2, 5'h1f, 1'b0, OP_DOUBLEWORD_ADDRESS_ADD_CST, UNIT_D, 1'b0));
    chkr("dw const", 6'd7, 32'h1f8);
    $display("test dword add done");
    apb(1'b1, OFF_PCBASE, 32'h0100_0000);
    run(kpc(7'h30, 3'h5));
    chkr("pc add", 6'd35, 32'h0100_00c0);
    // the next issue lands in the nop cycles and must stall
    apb(1'b1, OFF_INSTR, kpc(7'h30, 3'h5));
    run(kpc(7'h7f, 3'h7));
    chkr("pc add neg", 6'd35, 32'h00ff_fffc);
    $display("test pc add done");
    setr(6'd1, 32'hf7a1_302a);
    setr(6'd33, 32'h02b6_e724);
    // unit code 3 is refused, so nothing may be written then
    for (int u = 0; u < 4; u++) begin
      setr(6'd2, 32'h0);
      run(ins(CREG_NONE, 1'b0, 5'd2, 5'd1, 5'd1, 1'b1, OP_AND_REG, u[1:0], 1'b0));
      chkr("and reg", 6'd2, (u == 3) ? 32'h0 : 32'h02a0_2020);
    end
    setr(6'd1, 32'h32e4_6936);
    for (int i = 0; i < 3; i++) begin
      run(ins(CREG_NONE, 1'b0, 5'd3, 5'd1, kc[i], 1'b0, OP_AND_CST, UNIT_L, 1'b0));
      chkr("and const", 6'd3, ke[i]);
    end
    $display("test and done");
    setr(6'd1, 32'h0000_00ff);
    setr(6'd32, 32'h0);
    for (int i = 0; i < 3; i++) begin
      setr(6'd3, 32'h5a5a_5a5a);
      run(ins(cc[i], cz[i], 5'd3, 5'd1, 5'h0f, 1'b0, OP_AND_CST, UNIT_L, 1'b0));
      chkr("condition", 6'd3, ce[i]);
    end
    $display("test condition done");
    setr(6'd1, 32'h0000_00f0);
    apb(1'b1, OFF_INSTR, ins(CREG_NONE, 1'b0, 5'd4, 5'd1, 5'h1f, 1'b0, OP_AND_CST, UNIT_S,
                             1'b0));
    run(ins(CREG_NONE, 1'b0, 5'd5, 5'd4, 5'h1c, 1'b0, OP_AND_CST, UNIT_D, 1'b0));
    chkr("back to back", 6'd5, 32'h0000_00f0);
    apb(1'b0, 12'h01c, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdat)
    $display("test back to back done");
    print_verdict();
  end
endmodule : test_apx_exec_unit
